// >>> design/safe_torque_off_logic.sv
`timescale 1ns/1ps
`include "sto_defines.svh"
// Notes on behaviour
// - channel permits only while input energised
// - either request inactive blocks output stage
// - output removed within 20 ms
// - no latching; run command restarts output
// - trip option holds stop until reset
// - discrepancy option holds standby until both
// - monitor switch forces code 96, state 00
// - writes to shared settings refused while on
// - switch off sets no assignment
// - monitor on only both off, no fault
// - internal fault keeps output blocked
// - release and shutoff limits, zero disables
// - trip code on dual shutoff request
module safe_torque_off_logic #(
    parameter int TICK_CYCLES = `STO_TICK_CYC
) (
    // clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // safety pins, high = contact closed
    input wire logic i_shutoff_request_a,
    input wire logic i_shutoff_request_b,
    input wire logic i_monitor_switch,
    // drive control, same clock
    input wire logic i_run_cmd,
    input wire logic i_error_reset,
    input wire logic i_diag_fault,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // outputs
    output logic o_drive_enable,
    output logic o_external_device_monitor,
    output logic o_shared_output_terminal,
    output logic o_irq
);

    sto_pkg::state_s st_q; // registered state
    sto_pkg::state_s st_d; // next state
    logic ch_a; // channel a permits
    logic ch_b; // channel b permits
    logic sw_on; // monitor switch on
    logic [3:0] ev; // interrupt events
    logic [12:0] lim; // active discrepancy limit
    logic wr; // apb write access
    logic setup; // apb setup cycle

    // reset image of the state
    localparam sto_pkg::state_s ST_RST = '{
        ch: sto_pkg::CH_OFF,
        ctrl: `STO_CTRL_RST,
        fsel: `STO_FN_NONE,
        act: `STO_ACT_NO,
        rel: `STO_DISC_RST,
        shut: `STO_DISC_RST,
        default: '0
    };

    // offset decode
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a[1:0] == 2'h0) && (a <= `STO_ADDR_IMSK);
    endfunction : reg_hit

    // read mux
    function automatic logic [31:0] reg_rd(input logic [7:0] a, input sto_pkg::state_s s);
        reg_rd = 32'h0;
        case (a)
            `STO_ADDR_CTRL: reg_rd = {28'h0, s.ctrl};
            `STO_ADDR_FSEL: reg_rd = {24'h0, s.fsel};
            `STO_ADDR_ACT: reg_rd = {24'h0, s.act};
            `STO_ADDR_REL: reg_rd = {19'h0, s.rel};
            `STO_ADDR_SHUT: reg_rd = {19'h0, s.shut};
            `STO_ADDR_STAT: reg_rd = {20'h0, s.ch, s.term, s.external_device_monitor, s.drive, s.dual, s.tripped,
                                      s.standby, s.sw_prev, s.filt[2], s.filt[1], s.filt[0]};
            `STO_ADDR_IST: reg_rd = {28'h0, s.ist};
            `STO_ADDR_IMSK: reg_rd = {28'h0, s.imsk};
            default: reg_rd = 32'h0;
        endcase
    endfunction : reg_rd

    // clamp a written time to the allowed span
    function automatic logic [12:0] clamp_t(input logic [31:0] w);
        clamp_t = (w > {19'h0, `STO_DISC_MAX}) ? `STO_DISC_MAX : w[12:0];
    endfunction : clamp_t

    assign ch_a = st_q.filt[0];
    assign ch_b = st_q.filt[1];
    assign sw_on = st_q.filt[2];
    assign lim = (st_q.ch == sto_pkg::CH_SPLIT_REL) ? st_q.rel : st_q.shut;
    assign wr = i_psel && i_penable && i_pwrite && reg_hit(i_paddr);
    assign setup = i_psel && !i_penable;

    // next-state logic
    always_comb begin
        st_d = st_q;
        ev = 4'h0;
        // three-stage pin sync, change taken once stages 2 and 3 agree
        st_d.s1 = {i_monitor_switch, i_shutoff_request_b, i_shutoff_request_a};
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < 3; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.filt[i] = st_q.s3[i];
            end
        end
        // channel pair tracking
        case (st_q.ch)
            sto_pkg::CH_OFF: begin
                if (ch_a && ch_b) begin
                    st_d.ch = sto_pkg::CH_ON;
                end else if (ch_a || ch_b) begin
                    st_d.ch = sto_pkg::CH_SPLIT_REL;
                end
            end
            sto_pkg::CH_SPLIT_REL, sto_pkg::CH_SPLIT_SHUT: begin
                if (ch_a && ch_b) begin
                    st_d.ch = sto_pkg::CH_ON;
                end else if (!ch_a && !ch_b) begin
                    st_d.ch = sto_pkg::CH_OFF;
                end
            end
            sto_pkg::CH_ON: begin
                if (!ch_a && !ch_b) begin
                    st_d.ch = sto_pkg::CH_OFF;
                end else if (!(ch_a && ch_b)) begin
                    st_d.ch = sto_pkg::CH_SPLIT_SHUT;
                end
            end
            default: st_d.ch = sto_pkg::CH_OFF;
        endcase
        // discrepancy timer: 10 ms ticks from first change
        if (st_d.ch != st_q.ch) begin
            st_d.sub = 18'h0;
            st_d.cnt = 13'h0;
        end else if (st_q.ch[0] != st_q.ch[1]) begin
            if (st_q.sub == 18'(TICK_CYCLES - 1)) begin
                st_d.sub = 18'h0;
                if (st_q.cnt != `STO_CNT_SAT) begin
                    st_d.cnt = st_q.cnt + 13'h1;
                end
            end else begin
                st_d.sub = st_q.sub + 18'h1;
            end
        end
        // standby on discrepancy overrun, left only with both permitted
        if (st_q.ctrl[`STO_CTRL_DISC] && (st_q.ch[0] != st_q.ch[1]) && (lim != 13'h0)
            && (st_q.cnt >= lim)) begin
            st_d.standby = 1'b1;
        end else if (ch_a && ch_b) begin
            st_d.standby = 1'b0;
        end
        // trip latches, error reset clears, a new request wins
        if (i_error_reset) begin
            st_d.tripped = 1'b0;
            st_d.dual = 1'b0;
        end
        if (st_q.ctrl[`STO_CTRL_TRIP] && !(ch_a && ch_b)) begin
            st_d.tripped = 1'b1;
        end
        if ((st_q.ctrl[`STO_CTRL_DISP] == `STO_DISP_TRIP) && !ch_a && !ch_b) begin
            st_d.dual = 1'b1;
        end
        // output stage gate, restarts with no latch
        st_d.drive = ch_a && ch_b && i_run_cmd && !i_diag_fault
            && !st_q.tripped && !st_q.standby && !st_q.dual;
        // monitor signal
        st_d.external_device_monitor = !ch_a && !ch_b && !i_diag_fault;
        // apb read capture in setup
        if (setup) begin
            st_d.prdata = reg_rd(i_paddr, st_q);
            st_d.pslverr = !reg_hit(i_paddr);
        end
        // apb writes at access edge
        if (wr) begin
            case (i_paddr)
                `STO_ADDR_CTRL: st_d.ctrl = i_pwdata[3:0];
                `STO_ADDR_FSEL: st_d.fsel = i_pwdata[7:0];
                `STO_ADDR_ACT: st_d.act = i_pwdata[7:0];
                `STO_ADDR_REL: st_d.rel = clamp_t(i_pwdata);
                `STO_ADDR_SHUT: st_d.shut = clamp_t(i_pwdata);
                `STO_ADDR_IST: st_d.ist = st_q.ist & ~i_pwdata[3:0];
                `STO_ADDR_IMSK: st_d.imsk = i_pwdata[3:0];
                default: st_d.ist = st_d.ist;
            endcase
        end
        // monitor switch owns the shared terminal settings
        if (sw_on) begin
            st_d.fsel = `STO_FN_MON;
            st_d.act = `STO_ACT_NO;
        end else if (st_q.sw_prev) begin
            st_d.fsel = `STO_FN_NONE;
        end
        st_d.sw_prev = sw_on;
        // shared terminal shows monitor when assigned, inverted if closed-type
        st_d.term = (st_q.fsel == `STO_FN_MON) && (st_d.external_device_monitor ^ st_q.act[0]);
        // sticky events, set beats clear
        ev[0] = st_q.drive && !st_d.drive;
        ev[1] = st_d.tripped && !st_q.tripped;
        ev[2] = st_d.standby && !st_q.standby;
        ev[3] = i_diag_fault;
        st_d.ist = st_d.ist | ev;
    end

    // state register, frozen while enable low
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            st_q <= ST_RST;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    // outputs
    assign o_pready = i_ce;
    assign o_prdata = st_q.prdata;
    assign o_pslverr = st_q.pslverr;
    assign o_drive_enable = st_q.drive;
    assign o_external_device_monitor = st_q.external_device_monitor;
    assign o_shared_output_terminal = st_q.term;
    assign o_irq = |(st_q.ist & st_q.imsk);

    // checks, run while enabled
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn || !i_ce);

    // response timer: cycles of drive while a request is inactive
    logic [18:0] resp_q;
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || (i_shutoff_request_a && i_shutoff_request_b) || !o_drive_enable) begin
            resp_q <= 19'h0;
        end else if (i_ce) begin
            resp_q <= resp_q + 19'h1;
        end
    end

    sequence req_low_s;
        (!i_shutoff_request_a || !i_shutoff_request_b) [*6];
    endsequence
    sequence sw_rise_s;
        !sw_on ##1 sw_on;
    endsequence

    AST_DRIVE_BOTH: assert property (o_drive_enable |-> $past(ch_a) && $past(ch_b))
        else $error("drive with a channel not permitting");
    AST_DRIVE_BLOCK: assert property (!ch_a |=> !o_drive_enable)
        else $error("drive not blocked after request");
    AST_RESP: assert property (req_low_s |-> !o_drive_enable)
        else $error("drive not removed in time");
    AST_RESP_CNT: assert property (resp_q < 19'(`STO_RESP_CYC))
        else $error("response time exceeded");
    AST_RESTART: assert property (ch_a && ch_b && i_run_cmd && !i_diag_fault && !st_q.tripped
        && !st_q.standby && !st_q.dual |=> o_drive_enable)
        else $error("no restart with run command");
    AST_TRIP_HOLD: assert property (st_q.tripped && !i_error_reset |=> st_q.tripped ##0 !o_drive_enable)
        else $error("trip released without reset");
    AST_STANDBY: assert property (st_q.standby && !(ch_a && ch_b) |=> st_q.standby)
        else $error("standby left early");
    AST_SW_FORCE: assert property (sw_rise_s |=> st_q.fsel == `STO_FN_MON && st_q.act == `STO_ACT_NO)
        else $error("monitor switch did not force codes");
    AST_SW_REJECT: assert property (sw_on && wr |=> st_q.fsel == `STO_FN_MON)
        else $error("write accepted while switch on");
    AST_SW_OFF: assert property (!sw_on && st_q.sw_prev |=> st_q.fsel == `STO_FN_NONE)
        else $error("switch off did not clear function");
    // compare from the second enabled edge on, the reset image leads the pins by one edge
    AST_EDM: assert property ($past(i_resetn) && $past(i_ce)
        |-> o_external_device_monitor == $past(!ch_a && !ch_b && !i_diag_fault))
        else $error("monitor output wrong");
    AST_FAULT: assert property (i_diag_fault |=> !o_drive_enable)
        else $error("drive during internal fault");
    AST_DISC_ZERO: assert property ($rose(st_q.standby) |-> $past(lim != 13'h0)
        && $past(st_q.ctrl[`STO_CTRL_DISC]))
        else $error("standby without enabled limit");
    AST_DUAL: assert property ($rose(st_q.dual) |-> $past(!ch_a && !ch_b))
        else $error("trip code without dual request");

    // sticky status and bus error checks
    AST_FAULT_EV: assert property (i_diag_fault |=> st_q.ist[3])
        else $error("fault event not recorded");
    AST_IST_HOLD: assert property (st_q.ist[0] && !(wr && (i_paddr == `STO_ADDR_IST)) |=> st_q.ist[0])
        else $error("status bit lost without clear");
    AST_SLVERR: assert property (setup && !reg_hit(i_paddr) |=> o_pslverr)
        else $error("unmapped access without error");
    // stored limits never exceed the allowed span
    AST_DISC_LIMIT: assert property (st_q.rel <= `STO_DISC_MAX && st_q.shut <= `STO_DISC_MAX)
        else $error("discrepancy limit above span");
    // monitor side of the shared terminal
    AST_EDM_FAULT: assert property (i_diag_fault |=> !o_external_device_monitor)
        else $error("monitor on during fault");
    AST_SW_LOCK_ACT: assert property (sw_on |=> st_q.act == `STO_ACT_NO)
        else $error("active state changed while switch on");
    AST_TERM_IDLE: assert property (st_q.fsel != `STO_FN_MON |=> !o_shared_output_terminal)
        else $error("terminal active without monitor function");

endmodule : safe_torque_off_logic

// >>> design/sto_defines.svh
`ifndef STO_DEFINES_SVH
`define STO_DEFINES_SVH
// register byte offsets
`define STO_ADDR_CTRL 8'h00
`define STO_ADDR_FSEL 8'h04
`define STO_ADDR_ACT 8'h08
`define STO_ADDR_REL 8'h0c
`define STO_ADDR_SHUT 8'h10
`define STO_ADDR_STAT 8'h14
`define STO_ADDR_IST 8'h18
`define STO_ADDR_IMSK 8'h1c
// control fields
`define STO_CTRL_TRIP 0
`define STO_CTRL_DISC 1
`define STO_CTRL_DISP 3:2
`define STO_CTRL_RST 4'h4
`define STO_DISP_TRIP 2'h2
// shared output terminal codes
`define STO_FN_MON 8'h60
`define STO_FN_NONE 8'h00
`define STO_ACT_NO 8'h00
// discrepancy times in 10 ms units
`define STO_DISC_RST 13'h0001
`define STO_DISC_MAX 13'h1770
`define STO_CNT_SAT 13'h1fff
// timing
`define STO_CLK_NS 50
`define STO_TICK_NS 10000000
`define STO_TICK_CYC (`STO_TICK_NS / `STO_CLK_NS)
`define STO_RESP_NS 20000000
`define STO_RESP_CYC (`STO_RESP_NS / `STO_CLK_NS)
`endif

// >>> design/sto_pkg.sv
package sto_pkg;
    // channel pair state, gray along off-split-on-split
    typedef enum logic [1:0] {
        CH_OFF = 2'h0,
        CH_SPLIT_REL = 2'h1,
        CH_ON = 2'h3,
        CH_SPLIT_SHUT = 2'h2
    } chan_e;
    // whole block state
    typedef struct packed {
        logic [2:0] s1; // sync stage 1 {switch,b,a}
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] filt; // agreed levels
        logic sw_prev; // switch level one cycle ago
        chan_e ch;
        logic [17:0] sub; // clocks within one 10 ms tick
        logic [12:0] cnt; // ticks since split
        logic standby;
        logic tripped;
        logic dual;
        logic drive;
        logic external_device_monitor;
        logic term;
        logic [3:0] ctrl;
        logic [7:0] fsel;
        logic [7:0] act;
        logic [12:0] rel;
        logic [12:0] shut;
        logic [3:0] ist;
        logic [3:0] imsk;
        logic [31:0] prdata;
        logic pslverr;
    } state_s;
endpackage : sto_pkg

// >>> verif/sto_switch_model.sv
`timescale 1ns/1ps
// two safety contacts; channel b trails a by a commanded skew
module sto_switch_model (
    // clock
    input wire logic i_mclk,
    // commanded contacts {b,a} and lag of b in cycles
    input wire logic [1:0] i_want,
    input wire logic [3:0] i_skew,
    // contact levels, high = closed
    output logic o_req_a,
    output logic o_req_b
);
    logic [3:0] lag_q = 4'h0; // cycles left before b follows
    initial begin
        o_req_a = 1'b0;
        o_req_b = 1'b0;
    end
    // contacts move just after an edge, never mid-cycle
    always @(posedge i_mclk) begin
        o_req_a <= i_want[0];
        if (i_want[1] == o_req_b) lag_q <= i_skew; // reload while matched
        else if (lag_q != 4'h0) lag_q <= lag_q - 4'h1;
        else o_req_b <= i_want[1];
    end
endmodule : sto_switch_model

// >>> verif/safe_torque_off_logic_tb_top.sv
`timescale 1ns/1ps
`include "sto_defines.svh"
// self-checking bench for the safe torque off block
module safe_torque_off_logic_tb_top;
    logic mclk = 1'b0; // 20 mhz control clock
    logic resetn = 1'b0; // sync reset, active low
    logic mon_sw = 1'b0; // monitor selector switch
    logic run = 1'b0; // run command
    logic err_rst = 1'b0; // error reset
    logic fault = 1'b0; // self-diagnosis fault
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, drive, external_device_monitor, term, irq; // design outputs
    logic [31:0] prdata;
    logic req_a, req_b; // contact levels
    logic [1:0] want = 2'h0; // commanded contacts {b,a}
    logic [3:0] skew = 4'h0; // lag of channel b
    logic [31:0] r; // last read word
    logic e; // last error flag
    int bad_count = 0;
    int total_checks = 0;
    always #25 mclk = ~mclk;
    sto_switch_model u_sw (.i_mclk(mclk), .i_want(want), .i_skew(skew), .o_req_a(req_a), .o_req_b(req_b));
    safe_torque_off_logic #(.TICK_CYCLES(4)) u_dut (.i_mclk(mclk), .i_resetn(resetn), .i_ce(1'b1),
        .i_shutoff_request_a(req_a), .i_shutoff_request_b(req_b), .i_monitor_switch(mon_sw),
        .i_run_cmd(run), .i_error_reset(err_rst), .i_diag_fault(fault), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .o_drive_enable(drive), .o_external_device_monitor(external_device_monitor),
        .o_shared_output_terminal(term), .o_irq(irq));
    // count one comparison, report a difference at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // single-bit comparison
    task automatic chb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chb
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    // one apb transfer, held until pready at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // set skew a cycle ahead, then command contacts and wait
    task automatic pins(input logic [1:0] w, input logic [3:0] s, input int n);
        skew <= s;
        @(posedge mclk);
        want <= w;
        cyc(n);
    endtask : pins
    // reset values, clamp and an unmapped word
    task automatic reg_reset();
        rd(`STO_ADDR_CTRL);
        chk(r, 32'h4);
        rd(`STO_ADDR_SHUT);
        chk(r, 32'h1);
        rd(8'h20);
        chk({31'h0, e}, 32'h1);
        wr(`STO_ADDR_REL, 32'h1b58);
        rd(`STO_ADDR_REL);
        chk(r, 32'h1770);
        wr(`STO_ADDR_REL, 32'h1);
    endtask : reg_reset
    // every single or dual request blocks, release restarts
    task automatic chan_matrix();
        run <= 1'b1;
        wr(`STO_ADDR_IMSK, 32'h1);
        pins(2'h3, 4'h0, 10);
        chb(drive, 1'b1);
        for (int i = 0; i < 3; i++) begin
            pins(2'(i), 4'h0, 10);
            chb(drive, 1'b0);
            chb(external_device_monitor, i == 0);
            chb(irq, 1'b1);
            wr(`STO_ADDR_IST, 32'h1);
            chb(irq, 1'b0);
            pins(2'h3, 4'h0, 10);
            chb(drive, 1'b1);
        end
        run <= 1'b0;
        cyc(3);
        chb(drive, 1'b0);
        run <= 1'b1;
        cyc(3);
        chb(drive, 1'b1);
    endtask : chan_matrix
    // internal fault blocks output and monitor
    task automatic fault_hold();
        fault <= 1'b1;
        cyc(3);
        chb(drive, 1'b0);
        rd(`STO_ADDR_IST);
        chk(r & 32'h8, 32'h8);
        pins(2'h0, 4'h0, 10);
        chb(external_device_monitor, 1'b0);
        fault <= 1'b0;
        cyc(3);
        chb(external_device_monitor, 1'b1);
    endtask : fault_hold
    // trip option holds stop until error reset
    task automatic trip_hold();
        pins(2'h3, 4'h0, 10);
        wr(`STO_ADDR_CTRL, 32'h5);
        pins(2'h1, 4'h0, 10);
        pins(2'h3, 4'h0, 10);
        chb(drive, 1'b0);
        err_rst <= 1'b1;
        cyc(3);
        err_rst <= 1'b0;
        cyc(3);
        chb(drive, 1'b1);
        wr(`STO_ADDR_CTRL, 32'h4);
    endtask : trip_hold
    // long split enters standby; zero limit disables the check
    task automatic disc_standby();
        pins(2'h0, 4'h0, 10);
        wr(`STO_ADDR_CTRL, 32'h6);
        pins(2'h3, 4'hf, 12);
        rd(`STO_ADDR_STAT);
        chk(r & 32'h10, 32'h10);
        cyc(15);
        chb(drive, 1'b1);
        wr(`STO_ADDR_SHUT, 32'h0);
        pins(2'h0, 4'hf, 12);
        rd(`STO_ADDR_STAT);
        chk(r & 32'h10, 32'h0);
        cyc(15);
        wr(`STO_ADDR_CTRL, 32'h4);
        wr(`STO_ADDR_SHUT, 32'h1);
    endtask : disc_standby
    // selector forces and locks the shared terminal settings
    task automatic monitor_switch();
        mon_sw <= 1'b1;
        cyc(8);
        rd(`STO_ADDR_FSEL);
        chk(r, 32'h60);
        wr(`STO_ADDR_FSEL, 32'h11);
        wr(`STO_ADDR_ACT, 32'h1);
        rd(`STO_ADDR_FSEL);
        chk(r, 32'h60);
        rd(`STO_ADDR_ACT);
        chk(r, 32'h0);
        chb(term, 1'b1);
        mon_sw <= 1'b0;
        cyc(8);
        rd(`STO_ADDR_FSEL);
        chk(r, 32'h0);
        wr(`STO_ADDR_FSEL, 32'h60);
        wr(`STO_ADDR_ACT, 32'h1);
        cyc(2);
        chb(term, 1'b0);
        wr(`STO_ADDR_FSEL, 32'h0);
    endtask : monitor_switch
    // trip code only on a dual request
    task automatic dual_trip();
        pins(2'h3, 4'h0, 10);
        wr(`STO_ADDR_CTRL, 32'h8);
        pins(2'h1, 4'h0, 10);
        rd(`STO_ADDR_STAT);
        chk(r & 32'h40, 32'h0);
        pins(2'h0, 4'h0, 10);
        rd(`STO_ADDR_STAT);
        chk(r & 32'h40, 32'h40);
    endtask : dual_trip
    task automatic close_out();
        if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        cyc(20);
        resetn <= 1'b1;
        cyc(6);
        reg_reset();
        chan_matrix();
        fault_hold();
        trip_hold();
        disc_standby();
        monitor_switch();
        dual_trip();
        close_out();
    end
    // watchdog against a hang
    initial begin
        cyc(5000);
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end
endmodule : safe_torque_off_logic_tb_top
